/* logic/udpth_pkg.sv */
/*
  Shared constants and carriers for the UDP stream transfer-header framer.
  Assumes one 100 MHz clock domain and 32-bit data words on both sides.
*/
// Function
// - A datagram of whole packets starts with one header word: version in 3..0, type in 7..4, sequence count in 31..8.
// - A segment datagram adds a word with channel id in 15..0, channel sequence in 23..16 and zero in 31..24, then a 32-bit segment offset word.
// - Every datagram streamed over Ethernet carries the transfer header, since recorded packets may reach 128M or 512K bytes.
// - Each payload is the header immediately followed by packet data, in the recording byte order.
// - Streaming is optional and only runs while a publish request from the remote party stands; publish gates only new descriptors, not a datagram under way.
// - Internally added processing such as error-correction and physical framing words is removed before data leaves.
// - The message type is 0000 for whole packets and 0001 for a segment.
// - The 24-bit message sequence count rises by one for every datagram, segment datagrams included.
// - Datagrams hold only whole packets or one segment, packets go in recording order, segments by rising offset; a non-rising offset
//   straight after a segment of the same channel and packet is sent and flagged.
package udpth_pkg;

  // Header field layout
  localparam int VER_LSB = 0;
  localparam int VER_W = 4;
  localparam int TYPE_LSB = 4;
  localparam int TYPE_W = 4;
  localparam int SEQ_LSB = 8;
  localparam int SEQ_W = 24;
  localparam int CHID_LSB = 0;
  localparam int CHID_W = 16;
  localparam int CSEQ_LSB = 16;
  localparam int CSEQ_W = 8;
  localparam int RSVD_LSB = 24;
  localparam int RSVD_W = 8;
  localparam int WORD_W = 32;

  // Field codes
  localparam logic [VER_W-1:0] VERSION_1 = 4'h1;
  localparam logic [TYPE_W-1:0] TYPE_FULL = 4'h0;
  localparam logic [TYPE_W-1:0] TYPE_SEG = 4'h1;
  localparam logic [RSVD_W-1:0] RSVD_VAL = 8'h00;
  localparam logic [SEQ_W-1:0] SEQ_RESET = 24'h000000;
  localparam logic [SEQ_W-1:0] SEQ_ONE = 24'h000001;

  // Largest recorded packets; segment offset must span them
  localparam longint MAX_PKT_BYTES = 64'h0000_0000_0800_0000;
  localparam longint SMALL_PKT_BYTES = 64'h0000_0000_0008_0000;

  // Buffer depth in words
  localparam int FIFO_DEPTH = 32;

  // Datagram descriptor
  typedef struct packed {
    logic seg;
    logic [CHID_W-1:0] chan_id;
    logic [CSEQ_W-1:0] chan_seq;
    logic [WORD_W-1:0] seg_offset;
  } udpth_desc_s;

  // Incoming recorded word
  typedef struct packed {
    logic [WORD_W-1:0] data;
    logic last;
    logic strip;
  } udpth_in_s;

  // Clean word on the buffer and the payload output
  typedef struct packed {
    logic [WORD_W-1:0] data;
    logic last;
  } udpth_word_s;

  typedef enum logic [2:0] {
    ST_IDLE, ST_HDR0, ST_HDR1, ST_HDR2, ST_DATA
  } udpth_state_e;

endpackage

/* logic/udpth_fifo.sv */
/*
  Synchronous first-in first-out buffer with valid/ready on both sides.
  Assumes one clock; the output word is shown while o_rd_valid is high.
*/
module udpth_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Fill side
  input wire logic i_wr_valid,
  input wire logic [WIDTH-1:0] i_wr_data,
  output logic o_wr_ready,
  // Drain side
  output logic o_rd_valid,
  output logic [WIDTH-1:0] o_rd_data,
  input wire logic i_rd_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_reg, wr_ptr_next;
  logic [AW:0] rd_ptr_reg, rd_ptr_next;
  logic do_wr, do_rd, full, empty;

  // Extra pointer bit tells full from empty
  assign empty = (wr_ptr_reg == rd_ptr_reg);
  assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign o_wr_ready = !full;
  assign o_rd_valid = !empty;
  assign o_rd_data = mem[rd_ptr_reg[AW-1:0]];
  assign do_wr = i_wr_valid && !full;
  assign do_rd = i_rd_ready && !empty;

  // Pointer advance
  always_comb begin
    wr_ptr_next = wr_ptr_reg + (AW+1)'(do_wr);
    rd_ptr_next = rd_ptr_reg + (AW+1)'(do_rd);
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
    end
  end

  // Storage has no reset; only written words are ever read
  always_ff @(posedge i_sys_clk) begin
    if (do_wr) begin
      mem[wr_ptr_reg[AW-1:0]] <= i_wr_data;
    end
  end
endmodule

/* logic/udpth_framer.sv */
/*
  Framer that prefixes streamed recorded data with the UDP transfer header.
  Assumes a MAC/UDP stage downstream that adds IP and UDP headers and
  a source that marks internally added words with the strip flag.
*/
module udpth_framer #(
  parameter int DEPTH = udpth_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Publish request from the remote party
  input wire logic i_publish,
  // Datagram descriptor
  input wire logic i_desc_valid,
  input wire udpth_pkg::udpth_desc_s i_desc,
  output logic o_desc_ready,
  // Recorded data in
  input wire logic i_in_valid,
  input wire udpth_pkg::udpth_in_s i_in,
  output logic o_in_ready,
  // Payload out
  output logic o_tx_valid,
  output udpth_pkg::udpth_word_s o_tx,
  input wire logic i_tx_ready,
  // Status
  output logic [udpth_pkg::SEQ_W-1:0] o_seq_count,
  output logic o_order_err
);
  localparam int WW = $bits(udpth_pkg::udpth_word_s);

  udpth_pkg::udpth_state_e state_reg, state_next;
  udpth_pkg::udpth_desc_s desc_reg, desc_next;
  udpth_pkg::udpth_word_s out_reg, out_next;
  udpth_pkg::udpth_word_s fifo_word;
  logic [udpth_pkg::SEQ_W-1:0] seq_reg, seq_next;
  logic out_valid_reg, out_valid_next;
  logic hdr0_reg, hdr0_next;
  logic rdy_reg, rdy_next;
  logic err_reg, err_next;
  logic last_ok_reg, last_ok_next;
  logic [udpth_pkg::CHID_W-1:0] last_ch_reg, last_ch_next;
  logic [udpth_pkg::CSEQ_W-1:0] last_cs_reg, last_cs_next;
  logic [udpth_pkg::WORD_W-1:0] last_off_reg, last_off_next;
  logic adv, take, fifo_wr, fifo_wr_ready, fifo_valid, fifo_pop;
  logic [WW-1:0] fifo_rd_bits;
  localparam int CW = $clog2(DEPTH) + 1;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic in_rdy_reg, in_rdy_next;

  // Header word builders
  // fixed version and type codes
  function automatic logic [udpth_pkg::WORD_W-1:0] hdr_word0(
    input logic [udpth_pkg::SEQ_W-1:0] seq, input logic seg);
    logic [udpth_pkg::TYPE_W-1:0] typ;
    typ = seg ? udpth_pkg::TYPE_SEG : udpth_pkg::TYPE_FULL;
    return {seq, typ, udpth_pkg::VERSION_1};
  endfunction

  function automatic logic [udpth_pkg::WORD_W-1:0] hdr_word1(
    input udpth_pkg::udpth_desc_s d);
    return {udpth_pkg::RSVD_VAL, d.chan_seq, d.chan_id};
  endfunction

  // strip internal words
  // Stripped words are taken but never stored, so they cost no space
  assign fifo_wr = i_in_valid && !i_in.strip;
  assign o_in_ready = in_rdy_reg;

  udpth_fifo #(
    .WIDTH(WW),
    .DEPTH(DEPTH)
  ) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_wr_valid(fifo_wr),
    .i_wr_data({i_in.data, i_in.last}),
    .o_wr_ready(fifo_wr_ready),
    .o_rd_valid(fifo_valid),
    .o_rd_data(fifo_rd_bits),
    .i_rd_ready(fifo_pop)
  );

  assign fifo_word = udpth_pkg::udpth_word_s'(fifo_rd_bits);

  // Output stage may load a new word when empty or being drained
  assign adv = !out_valid_reg || i_tx_ready;
  assign take = rdy_reg && i_desc_valid && (state_reg == udpth_pkg::ST_IDLE);
  assign fifo_pop = (state_reg == udpth_pkg::ST_DATA) && adv;

  // input ready from a flop
  // Stored-word count mirrors the buffer; costs a counter, avoids a
  // combinational path from the buffer pointers to the source
  always_comb begin
    cnt_next = cnt_reg;
    if (fifo_wr && in_rdy_reg) begin
      cnt_next = cnt_next + CW'(1);
    end
    if (fifo_pop && fifo_valid) begin
      cnt_next = cnt_next - CW'(1);
    end
    in_rdy_next = (cnt_next != CW'(DEPTH));
  end

  // Framing sequence and output word
  always_comb begin
    state_next = state_reg;
    desc_next = desc_reg;
    seq_next = seq_reg;
    out_next = out_reg;
    out_valid_next = out_valid_reg && !i_tx_ready;
    hdr0_next = hdr0_reg && !i_tx_ready;
    unique case (state_reg)
      udpth_pkg::ST_IDLE: begin
        if (take) begin
          desc_next = i_desc;
          state_next = udpth_pkg::ST_HDR0;
        end
      end
      udpth_pkg::ST_HDR0: begin
        if (adv) begin
          out_next.data = hdr_word0(seq_reg, desc_reg.seg);
          out_next.last = 1'b0;
          out_valid_next = 1'b1;
          hdr0_next = 1'b1;
          // count per datagram; wraps by width
          seq_next = seq_reg + udpth_pkg::SEQ_ONE;
          state_next = desc_reg.seg ? udpth_pkg::ST_HDR1 :
                                      udpth_pkg::ST_DATA;
        end
      end
      udpth_pkg::ST_HDR1: begin
        if (adv) begin
          out_next.data = hdr_word1(desc_reg);
          out_next.last = 1'b0;
          out_valid_next = 1'b1;
          state_next = udpth_pkg::ST_HDR2;
        end
      end
      udpth_pkg::ST_HDR2: begin
        if (adv) begin
          out_next.data = desc_reg.seg_offset;
          out_next.last = 1'b0;
          out_valid_next = 1'b1;
          state_next = udpth_pkg::ST_DATA;
        end
      end
      udpth_pkg::ST_DATA: begin
        // data right after header, words unchanged
        if (adv && fifo_valid) begin
          out_next = fifo_word;
          out_valid_next = 1'b1;
          if (fifo_word.last) begin
            state_next = udpth_pkg::ST_IDLE;
          end
        end
      end
    endcase
  end

  // Descriptor ready only while idle with publish standing
  always_comb begin
    rdy_next = i_publish && (state_next == udpth_pkg::ST_IDLE) && !take;
  end

  // segment order check per channel and packet
  // A segment of the same packet must rise in offset; a repeated offset also flags
  always_comb begin
    err_next = 1'b0;
    last_ok_next = last_ok_reg;
    last_ch_next = last_ch_reg;
    last_cs_next = last_cs_reg;
    last_off_next = last_off_reg;
    if (take) begin
      if (i_desc.seg) begin
        err_next = last_ok_reg && (i_desc.chan_id == last_ch_reg) &&
                   (i_desc.chan_seq == last_cs_reg) &&
                   (i_desc.seg_offset <= last_off_reg);
        last_ok_next = 1'b1;
        last_ch_next = i_desc.chan_id;
        last_cs_next = i_desc.chan_seq;
        last_off_next = i_desc.seg_offset;
      end else begin
        last_ok_next = 1'b0;
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= udpth_pkg::ST_IDLE;
      desc_reg <= '0;
      seq_reg <= udpth_pkg::SEQ_RESET;
      out_reg <= '0;
      out_valid_reg <= 1'b0;
      hdr0_reg <= 1'b0;
      rdy_reg <= 1'b0;
      err_reg <= 1'b0;
      last_ok_reg <= 1'b0;
      last_ch_reg <= '0;
      last_cs_reg <= '0;
      last_off_reg <= '0;
      cnt_reg <= '0;
      in_rdy_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      desc_reg <= desc_next;
      seq_reg <= seq_next;
      out_reg <= out_next;
      out_valid_reg <= out_valid_next;
      hdr0_reg <= hdr0_next;
      rdy_reg <= rdy_next;
      err_reg <= err_next;
      last_ok_reg <= last_ok_next;
      last_ch_reg <= last_ch_next;
      last_cs_reg <= last_cs_next;
      last_off_reg <= last_off_next;
      cnt_reg <= cnt_next;
      in_rdy_reg <= in_rdy_next;
    end
  end

  // Outputs straight from flops
  assign o_tx = out_reg;
  assign o_tx_valid = out_valid_reg;
  assign o_desc_ready = rdy_reg;
  assign o_seq_count = seq_reg;
  assign o_order_err = err_reg;

  // Checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  sequence s_hdr0_sent;
    state_reg == udpth_pkg::ST_HDR0 && adv;
  endsequence

  sequence s_seg_words;
    (state_reg == udpth_pkg::ST_HDR1 && adv) ##1
    (out_valid_reg && out_reg.data[udpth_pkg::RSVD_LSB +:
      udpth_pkg::RSVD_W] == udpth_pkg::RSVD_VAL);
  endsequence

  a_hdr_version: assert property (out_valid_reg && hdr0_reg |->
    out_reg.data[udpth_pkg::VER_LSB +: udpth_pkg::VER_W] ==
    udpth_pkg::VERSION_1) else $error("bad header version");

  a_hdr_type: assert property (out_valid_reg && hdr0_reg |->
    out_reg.data[udpth_pkg::TYPE_LSB +: udpth_pkg::TYPE_W] ==
    (desc_reg.seg ? udpth_pkg::TYPE_SEG : udpth_pkg::TYPE_FULL))
    else $error("bad message type");

  // sequence field carries count before the step
  a_hdr_seqfld: assert property (s_hdr0_sent |=>
    out_reg.data[udpth_pkg::SEQ_LSB +: udpth_pkg::SEQ_W] ==
    seq_reg - udpth_pkg::SEQ_ONE) else $error("sequence field wrong");

  a_seq_step: assert property (
    !(state_reg == udpth_pkg::ST_HDR0 && adv)
    |=> $stable(seq_reg)) else $error("sequence moved without datagram");

  a_seq_wrap: assert property (s_hdr0_sent and seq_reg == '1 |=>
    seq_reg == udpth_pkg::SEQ_RESET) else $error("sequence did not wrap");

  a_seg_layout: assert property (s_seg_words |=>
    (out_valid_reg && !i_tx_ready)[*1] or
    (state_reg == udpth_pkg::ST_HDR2 || state_reg == udpth_pkg::ST_DATA))
    else $error("segment header order wrong");

  // header precedes data after every take
  a_hdr_first: assert property (take |=> state_reg ==
    udpth_pkg::ST_HDR0 ##1 state_reg != udpth_pkg::ST_IDLE)
    else $error("datagram without header");

  a_publish: assert property (!i_publish |=> !o_desc_ready)
    else $error("ready without publish");

  a_strip: assert property (i_in_valid && i_in.strip |->
    !u_fifo.do_wr) else $error("internal word stored");

  a_order_err: assert property (o_order_err |->
    $past(take) && $past(i_desc.seg)) else $error("spurious order error");

  a_in_ready: assert property (o_in_ready == fifo_wr_ready)
    else $error("input ready out of step");

  a_tx_hold: assert property (o_tx_valid && !i_tx_ready |=>
    o_tx_valid && $stable(o_tx)) else $error("payload word dropped");

  a_desc_drop: assert property (take |=> !o_desc_ready)
    else $error("ready stayed after take");
endmodule

/* tb/udpth_sink.sv */
/*
  Network subscriber model: takes framer payload words into a queue.
  Assumes the bench reads and empties the queue by hierarchical name.
*/
module udpth_sink (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Payload from the framer
  input wire logic i_tx_valid,
  input wire udpth_pkg::udpth_word_s i_tx,
  output logic o_tx_ready,
  // Stall every other cycle when high
  input wire logic i_slow
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [32:0] words[$];
  logic toggle_reg;
  // Ready moves off the sampling edge; slow mode halves throughput
  always @(negedge i_sys_clk) begin
    toggle_reg <= ~toggle_reg & ~i_rst;
  end
  assign o_tx_ready = ~i_slow | toggle_reg;
  // Capture every accepted word with its last flag
  always @(posedge i_sys_clk) begin
    if (!i_rst && i_tx_valid && o_tx_ready) begin
      words.push_back({i_tx.data, i_tx.last});
    end
  end
endmodule

/* tb/tb_top.sv */
/*
  Self-checking bench for the transfer-header framer.
  Assumes the framer package and a subscriber model that queues words.
*/
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin \
  n_errors++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] CH_ID = 16'hbeef;
  localparam logic [7:0] CH_SEQ = 8'h5a;
  logic i_sys_clk, i_rst, i_publish, i_desc_valid, i_in_valid, i_slow;
  udpth_pkg::udpth_desc_s i_desc;
  udpth_pkg::udpth_in_s i_in;
  udpth_pkg::udpth_word_s o_tx;
  logic o_desc_ready, o_in_ready, o_tx_valid, tx_ready, o_order_err;
  logic [23:0] o_seq_count;
  logic [23:0] exp_seq;
  int n_errors, compares, n_oerr;

  udpth_framer #(.DEPTH(32)) udpth_framer_inst (.i_sys_clk(i_sys_clk),
    .i_rst(i_rst), .i_publish(i_publish), .i_desc_valid(i_desc_valid),
    .i_desc(i_desc), .o_desc_ready(o_desc_ready), .i_in_valid(i_in_valid),
    .i_in(i_in), .o_in_ready(o_in_ready), .o_tx_valid(o_tx_valid),
    .o_tx(o_tx), .i_tx_ready(tx_ready), .o_seq_count(o_seq_count),
    .o_order_err(o_order_err));
  udpth_sink udpth_sink_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_tx_valid(o_tx_valid), .i_tx(o_tx), .o_tx_ready(tx_ready),
    .i_slow(i_slow));

  // Free-running 100 MHz clock
  initial begin
    i_sys_clk = 0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  // Order error pulses are counted, not judged per cycle
  always @(posedge i_sys_clk) begin
    if (o_order_err === 1'b1) n_oerr++;
  end

  task automatic give_verdict();
    $display("compares=%0d errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Offer one word from a falling edge; valid stays up for the next push
  task automatic push(input logic [31:0] d, input logic l, input logic s,
                      input int tries, output bit ok);
    bit rdy;
    ok = 0;
    i_in = '{data: d, last: l, strip: s};
    i_in_valid = 1;
    for (int k = 0; k < tries && !ok; k++) begin
      #1 rdy = o_in_ready;
      @(posedge i_sys_clk);
      ok = rdy;
      @(negedge i_sys_clk);
    end
  endtask

  // One datagram: optional data fill, descriptor, then payload check
  task automatic dgram(input logic seg, input logic [31:0] off,
                       input int n, input logic [31:0] base, input bit fill);
    logic [32:0] exp[$];
    logic [32:0] w[$];
    bit ok, rdy;
    int k, h;
    h = seg ? 3 : 1;
    if (fill) begin
      push(32'hdead_beef, 1'b0, 1'b1, 40, ok);
      for (k = 0; k < n; k++) begin
        push(base + 32'(k), k == n - 1, 1'b0, 40, ok);
        `CHK(ok, 1'b1)
        if (!ok) give_verdict();
      end
      i_in_valid = 0;
    end
    i_desc = '{seg: seg, chan_id: CH_ID, chan_seq: CH_SEQ, seg_offset: off};
    i_desc_valid = 1;
    ok = 0;
    for (k = 0; k < 40 && !ok; k++) begin
      #1 rdy = o_desc_ready;
      @(posedge i_sys_clk);
      ok = rdy;
      @(negedge i_sys_clk);
    end
    i_desc_valid = 0;
    `CHK(ok, 1'b1)
    if (!ok) give_verdict();
    exp.push_back({exp_seq, seg ? udpth_pkg::TYPE_SEG : udpth_pkg::TYPE_FULL,
                   udpth_pkg::VERSION_1, 1'b0});
    if (seg) begin
      exp.push_back({8'h00, CH_SEQ, CH_ID, 1'b0});
      exp.push_back({off, 1'b0});
    end
    for (k = 0; k < n; k++) exp.push_back({base + 32'(k), k == n - 1});
    // Bounded wait for the whole payload, then a margin for extras
    for (k = 0; k < 300 && udpth_sink_inst.words.size() < exp.size(); k++)
      @(negedge i_sys_clk);
    if (udpth_sink_inst.words.size() < exp.size()) begin
      n_errors++;
      give_verdict();
    end
    repeat (4) @(negedge i_sys_clk);
    w = udpth_sink_inst.words;
    `CHK(w.size(), exp.size())
    `CHK(w[0], exp[0])
    `CHK(w[0][4:1], udpth_pkg::VERSION_1)
    `CHK(w[0][8:5], exp[0][8:5])
    if (seg) begin
      `CHK(w[1], exp[1])
      `CHK(w[2], exp[2])
    end
    for (k = h; k < exp.size(); k++) `CHK(w[k], exp[k])
    udpth_sink_inst.words.delete();
    exp_seq++;
    `CHK(o_seq_count, exp_seq)
  endtask

  // Fill the buffer with no publish, see it refuse, then drain it slowly
  task automatic t_fill();
    bit ok;
    i_publish = 0;
    for (int k = 0; k < 32; k++) begin
      push(32'h100 + 32'(k), k == 31, 1'b0, 40, ok);
      `CHK(ok, 1'b1)
      if (!ok) give_verdict();
    end
    push(32'hffff_ffff, 1'b1, 1'b0, 3, ok);
    i_in_valid = 0;
    `CHK(ok, 1'b0)
    `CHK(o_desc_ready, 1'b0)
    i_publish = 1;
    i_slow = 1;
    dgram(1'b0, 32'h0, 32, 32'h100, 0);
    i_slow = 0;
    $display("test fill done");
  endtask

  // Two whole-packet words behind a one-word header
  task automatic t_full();
    dgram(1'b0, 32'h0, 2, 32'h1000_0000, 1);
    $display("test full done");
  endtask

  // Three segments to a stalling subscriber; the last one goes back
  task automatic t_seg();
    i_slow = 1;
    dgram(1'b1, 32'h100, 3, 32'h2000_0000, 1);
    dgram(1'b1, 32'h200, 1, 32'h3000_0000, 1);
    `CHK(n_oerr, 0)
    dgram(1'b1, 32'h80, 2, 32'h4000_0000, 1);
    `CHK(n_oerr, 1)
    i_slow = 0;
    $display("test seg done");
  endtask

  // Mid-run reset: outputs go idle, count restarts, then a lower-offset segment after the reset is not flagged
  task automatic t_reset();
    i_rst = 1;
    @(negedge i_sys_clk);
    `CHK(o_tx_valid, 1'b0)
    `CHK(o_in_ready, 1'b1)
    `CHK(o_desc_ready, 1'b0)
    `CHK(o_seq_count, 24'h000000)
    `CHK(o_order_err, 1'b0)
    @(negedge i_sys_clk);
    i_rst = 0;
    exp_seq = 24'h000000;
    @(negedge i_sys_clk);
    `CHK(o_desc_ready, 1'b1)
    dgram(1'b1, 32'h40, 1, 32'h5000_0000, 1);
    `CHK(n_oerr, 1)
    $display("test reset done");
  endtask

  // Main sequence
  initial begin
    i_rst = 1;
    i_publish = 0;
    i_desc_valid = 0;
    i_in_valid = 0;
    i_slow = 0;
    i_desc = '0;
    i_in = '0;
    exp_seq = 24'h000000;
    repeat (2) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_rst = 0;
    `CHK(o_seq_count, 24'h000000)
    i_publish = 1;
    t_full();
    t_seg();
    t_fill();
    t_reset();
    give_verdict();
  end
endmodule
